/* File: core/jsfp_core.v */
`include "jsfp_defs.vh"

// Overview of operation
// - Start on internal clock; switch to main clock input only if above 32 kHz.
// - Comms chain is 38 bits: data 32, address 5, direction 1.
// - Register access happens on entry to Update-DR.
// - Flags register at address 0x04, data register at 0x05.
// - Flags register is read-only and carries the handshake flags.
// - Bit 1 set when a word waits for the programmer.
// - Bit 0 set while a written word is not yet taken.
// - Read command: count shifted 16 ORed with opcode, then start address.
// - Start address is word aligned; address advances after each word.
// - Memory is read as 32-bit words from any valid address.
module jsfp_core #(
    parameter DET_W      = 16,
    parameter DET_CYCLES = `JSFP_SLOW_PERIOD_NS / `JSFP_CLK_PERIOD_NS
) (
    input  wire        i_clk_sys,
    input  wire        i_rst_n,
    input  wire        i_ce,
    input  wire        i_test_select_input,
    input  wire        i_prog_enable_sel_a,
    input  wire        i_prog_enable_sel_b,
    input  wire        i_prog_enable_sel_c,
    input  wire        i_main_clock_input,
    input  wire        i_tck,
    input  wire        i_tms,
    input  wire        i_tdi,
    output reg         o_tdo,
    output reg         o_tdo_oe,
    output reg         o_test_mode,
    output reg         o_prog_mode,
    output reg         o_ready,
    output reg         o_clk_ext_sel,
    output reg         o_mem_req,
    output reg  [31:0] o_mem_addr,
    input  wire [31:0] i_mem_rdata,
    input  wire        i_mem_ack
);

// ****************************************
// TAP states and engine states
// ****************************************
localparam [3:0] T_TLR = 4'h0, T_RTI = 4'h1, T_SDR = 4'h2, T_CDR = 4'h3;
localparam [3:0] T_SHD = 4'h4, T_E1D = 4'h5, T_PDR = 4'h6, T_E2D = 4'h7;
localparam [3:0] T_UDR = 4'h8, T_SIR = 4'h9, T_CIR = 4'ha, T_SHI = 4'hb;
localparam [3:0] T_E1I = 4'hc, T_PIR = 4'hd, T_E2I = 4'he, T_UIR = 4'hf;
localparam [2:0] E_CMD = 3'h0, E_ADDR = 3'h1, E_FETCH = 3'h2;
localparam [2:0] E_WAIT = 3'h3, E_HOLD = 3'h4;
localparam [DET_W-1:0] DET_LAST = DET_CYCLES[DET_W-1:0] - 1'b1;

// ****************************************
// TAP next-state function
// ****************************************
function [3:0] tap_next;
    input [3:0] s;
    input       tms;
    begin
        case (s)
            T_TLR: tap_next = tms ? T_TLR : T_RTI;
            T_RTI: tap_next = tms ? T_SDR : T_RTI;
            T_SDR: tap_next = tms ? T_SIR : T_CDR;
            T_CDR: tap_next = tms ? T_E1D : T_SHD;
            T_SHD: tap_next = tms ? T_E1D : T_SHD;
            T_E1D: tap_next = tms ? T_UDR : T_PDR;
            T_PDR: tap_next = tms ? T_E2D : T_PDR;
            T_E2D: tap_next = tms ? T_UDR : T_SHD;
            T_UDR: tap_next = tms ? T_SDR : T_RTI;
            T_SIR: tap_next = tms ? T_TLR : T_CIR;
            T_CIR: tap_next = tms ? T_E1I : T_SHI;
            T_SHI: tap_next = tms ? T_E1I : T_SHI;
            T_E1I: tap_next = tms ? T_UIR : T_PIR;
            T_PIR: tap_next = tms ? T_E2I : T_PIR;
            T_E2I: tap_next = tms ? T_UIR : T_SHI;
            default: tap_next = tms ? T_SDR : T_RTI;
        endcase
    end
endfunction

// ****************************************
// Pin synchronisers
// ****************************************
reg  [3:0] pins_s1;
reg  [3:0] pins_s2;
reg  [2:0] link_s1;
reg  [2:0] link_s2;
reg        tck_d;
reg        mclk_s1;
reg        mclk_s2;
reg        mclk_d;

always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
        pins_s1 <= 4'h0;
        pins_s2 <= 4'h0;
        link_s1 <= 3'h7;
        link_s2 <= 3'h7;
        tck_d   <= 1'b1;
        mclk_s1 <= 1'b0;
        mclk_s2 <= 1'b0;
        mclk_d  <= 1'b0;
    end else if (i_ce) begin
        pins_s1 <= {i_test_select_input, i_prog_enable_sel_a,
                    i_prog_enable_sel_b, i_prog_enable_sel_c};
        pins_s2 <= pins_s1;
        link_s1 <= {i_tck, i_tms, i_tdi};
        link_s2 <= link_s1;
        tck_d   <= link_s2[2];
        mclk_s1 <= i_main_clock_input;
        mclk_s2 <= mclk_s1;
        mclk_d  <= mclk_s2;
    end
end

wire tck_rise  = link_s2[2] & ~tck_d;
wire tck_fall  = ~link_s2[2] & tck_d;
wire tms_s     = link_s2[1];
wire tdi_s     = link_s2[0];
wire mclk_rise = mclk_s2 & ~mclk_d;

// ****************************************
// Main clock detection
// ****************************************
reg [DET_W-1:0] det_cnt;
reg [1:0]       det_edges;

always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
        det_cnt       <= {DET_W{1'b0}};
        det_edges     <= 2'h0;
        o_ready       <= 1'b0;
        o_clk_ext_sel <= 1'b0;
    end else if (i_ce && !o_ready) begin
        det_cnt <= det_cnt + 1'b1;
        if (mclk_rise && det_edges != 2'h2)
            det_edges <= det_edges + 1'b1;
        if (det_cnt == DET_LAST) begin
            o_ready       <= 1'b1;
            o_clk_ext_sel <= (det_edges == 2'h2);
        end
    end
end

// ****************************************
// TAP controller and scan chain
// ****************************************
reg  [3:0]                 tap;
reg  [`JSFP_IR_W-1:0]      ir;
reg  [`JSFP_IR_W-1:0]      ir_sh;
reg  [`JSFP_CHAIN_W-1:0]   chain;
reg                        entry_armed;
reg  [31:0]                rd_hold;
reg  [31:0]                wr_word;
reg  [31:0]                out_word;
reg                        wr_pending;
reg                        rd_avail;
reg  [2:0]                 eng;

wire [3:0] tap_nx    = tap_next(tap, tms_s);
wire       comms_sel = (ir == `JSFP_IR_COMMS) && o_prog_mode;
wire       upd_dr    = tck_rise && o_test_mode && (tap_nx == T_UDR);
wire       acc       = upd_dr && comms_sel && o_ready;
wire [4:0] acc_addr  = chain[`JSFP_ADDR_MSB:`JSFP_ADDR_LSB];
wire       acc_wr    = chain[`JSFP_RW_BIT];
wire       set_wpend = acc && acc_wr && (acc_addr == `JSFP_REG_DATA);
wire       clr_ravl  = acc && !acc_wr && (acc_addr == `JSFP_REG_DATA);
wire       flags_rd  = acc && !acc_wr && (acc_addr == `JSFP_REG_FLAGS);
wire       take      = o_ready && wr_pending && (eng == E_CMD || eng == E_ADDR);
wire       set_ravl  = (eng == E_WAIT) && i_mem_ack;

reg  [`JSFP_CHAIN_W-1:0] next_chain;

always @* begin
    next_chain = chain;
    if (comms_sel)
        next_chain = {tdi_s, chain[`JSFP_CHAIN_W-1:1]};
    else if (ir == `JSFP_IR_ENTRY)
        next_chain = {34'h0, tdi_s, chain[3:1]};
    else
        next_chain = {37'h0, tdi_s};
end

always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
        tap         <= T_TLR;
        ir          <= `JSFP_IR_BYPASS;
        ir_sh       <= {`JSFP_IR_W{1'b0}};
        chain       <= {`JSFP_CHAIN_W{1'b0}};
        entry_armed <= 1'b0;
        o_prog_mode <= 1'b0;
        o_test_mode <= 1'b0;
        o_tdo       <= 1'b0;
        o_tdo_oe    <= 1'b0;
        rd_hold     <= 32'h0;
    end else if (i_ce) begin
        o_test_mode <= pins_s2[3] & pins_s2[2] & pins_s2[1] & ~pins_s2[0];
        if (tck_rise && o_test_mode) begin
            tap <= tap_nx;
            case (tap)
                T_TLR: ir <= `JSFP_IR_BYPASS;
                T_CIR: ir_sh <= `JSFP_IR_CAPTURE;
                T_SHI: ir_sh <= {tdi_s, ir_sh[`JSFP_IR_W-1:1]};
                T_UIR: begin
                    ir <= ir_sh;
                    if (ir_sh == `JSFP_IR_COMMS && entry_armed)
                        o_prog_mode <= 1'b1;
                end
                T_CDR: chain <= {6'h00, rd_hold};
                T_SHD: chain <= next_chain;
                T_UDR: begin
                    if (ir == `JSFP_IR_ENTRY && chain[3:0] == `JSFP_DR_ENTRY)
                        entry_armed <= 1'b1;
                end
                default: ;
            endcase
        end
        if (tck_fall) begin
            o_tdo_oe <= (tap == T_SHD) || (tap == T_SHI);
            if (tap == T_SHD)
                o_tdo <= chain[0];
            else if (tap == T_SHI)
                o_tdo <= ir_sh[0];
        end
        if (flags_rd)
            rd_hold <= {30'h0, rd_avail, wr_pending};
        else if (clr_ravl)
            rd_hold <= out_word;
    end
end

// ****************************************
// Handshake flags
// ****************************************
always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
        wr_pending <= 1'b0;
        rd_avail   <= 1'b0;
        wr_word    <= 32'h0;
    end else if (i_ce) begin
        wr_pending <= set_wpend | (wr_pending & ~take);
        rd_avail   <= set_ravl | (rd_avail & ~clr_ravl);
        if (set_wpend)
            wr_word <= chain[`JSFP_DATA_W-1:0];
    end
end

// ****************************************
// Read command engine
// ****************************************
reg [15:0] words_left;

always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
        eng        <= E_CMD;
        words_left <= 16'h0;
        o_mem_req  <= 1'b0;
        o_mem_addr <= 32'h0;
        out_word   <= 32'h0;
    end else if (i_ce) begin
        case (eng)
            E_CMD: begin
                if (take && wr_word[`JSFP_OP_MSB:0] == `JSFP_OP_READ
                    && wr_word[`JSFP_CNT_MSB:`JSFP_CNT_LSB] != 16'h0) begin
                    words_left <= wr_word[`JSFP_CNT_MSB:`JSFP_CNT_LSB];
                    eng        <= E_ADDR;
                end
            end
            E_ADDR: begin
                if (take) begin
                    o_mem_addr <= wr_word & `JSFP_ALIGN_MASK;
                    eng        <= E_FETCH;
                end
            end
            E_FETCH: begin
                o_mem_req <= 1'b1;
                eng       <= E_WAIT;
            end
            E_WAIT: begin
                if (i_mem_ack) begin
                    o_mem_req  <= 1'b0;
                    out_word   <= i_mem_rdata;
                    words_left <= words_left - 1'b1;
                    eng        <= E_HOLD;
                end
            end
            E_HOLD: begin
                if (!rd_avail) begin
                    o_mem_addr <= o_mem_addr + `JSFP_WORD_STEP;
                    eng        <= (words_left == 16'h0) ? E_CMD : E_FETCH;
                end
            end
            default: eng <= E_CMD;
        endcase
    end
end

endmodule // jsfp_core

/* File: core/jsfp_defs.vh */
`ifndef JSFP_DEFS_VH
`define JSFP_DEFS_VH
// ****************************************
// Timing
// ****************************************
`define JSFP_CLK_PERIOD_NS  5
`define JSFP_SLOW_PERIOD_NS 31250
// ****************************************
// TAP instruction and entry values
// ****************************************
`define JSFP_IR_W           4
`define JSFP_IR_CAPTURE     4'h1
`define JSFP_IR_BYPASS      4'hf
`define JSFP_IR_ENTRY       4'h2
`define JSFP_DR_ENTRY       4'h2
`define JSFP_IR_COMMS       4'hc
// ****************************************
// Comms scan chain layout
// ****************************************
`define JSFP_CHAIN_W        38
`define JSFP_DATA_W         32
`define JSFP_ADDR_LSB       32
`define JSFP_ADDR_MSB       36
`define JSFP_RW_BIT         37
`define JSFP_REG_FLAGS      5'h04
`define JSFP_REG_DATA       5'h05
`define JSFP_FLAG_WPEND     0
`define JSFP_FLAG_RAVAIL    1
// ****************************************
// Read command word
// ****************************************
`define JSFP_CNT_LSB        16
`define JSFP_CNT_MSB        31
`define JSFP_OP_MSB         15
`define JSFP_OP_READ        16'h000f
`define JSFP_WORD_STEP      32'h00000004
`define JSFP_ALIGN_MASK     32'hfffffffc
`endif

/* File: bench/jsfp_core_properties.sv */
module jsfp_core_props #(
    parameter DET_W      = 16,
    parameter DET_CYCLES = 6250
) (
    input wire        i_clk_sys,
    input wire        i_rst_n,
    input wire        i_ce,
    input wire        i_test_select_input,
    input wire        i_prog_enable_sel_a,
    input wire        i_prog_enable_sel_b,
    input wire        i_prog_enable_sel_c,
    input wire        i_main_clock_input,
    input wire        i_tck,
    input wire        i_tms,
    input wire        i_tdi,
    input wire        o_tdo,
    input wire        o_tdo_oe,
    input wire        o_test_mode,
    input wire        o_prog_mode,
    input wire        o_ready,
    input wire        o_clk_ext_sel,
    input wire        o_mem_req,
    input wire [31:0] o_mem_addr,
    input wire [31:0] i_mem_rdata,
    input wire        i_mem_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    wire        sel_ok;
    reg  [31:0] cnt;
    assign sel_ok = i_test_select_input & i_prog_enable_sel_a & i_prog_enable_sel_b
                    & ~i_prog_enable_sel_c;
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 32'h0;
        end else if (i_ce && !o_ready) begin
            cnt <= cnt + 32'h1;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // ****************************************
    // Assertions
    // ****************************************
    mode_on_a: assert property (sel_ok [*5] |-> o_test_mode)
        else $error("test mode missing");
    mode_off_a: assert property (!sel_ok [*5] |-> !o_test_mode)
        else $error("test mode without pins");
    prog_sticky_a: assert property (o_prog_mode |=> o_prog_mode)
        else $error("prog mode dropped");
    prog_entry_a: assert property ($rose(o_prog_mode) |-> o_test_mode)
        else $error("prog mode outside test mode");
    ready_keep_a: assert property (o_ready |=> o_ready && $stable(o_clk_ext_sel))
        else $error("clock choice changed after ready");
    ready_time_a: assert property ($rose(o_ready) |->
        cnt >= DET_CYCLES - 2 && cnt <= DET_CYCLES + 1)
        else $error("ready at wrong time");
    req_hold_a: assert property (o_mem_req && !i_mem_ack |=>
        o_mem_req && $stable(o_mem_addr))
        else $error("request not held");
    req_align_a: assert property (o_mem_req |->
        o_mem_addr[1:0] == 2'b00 && o_ready && o_prog_mode)
        else $error("bad request");
    ack_drop_a: assert property (i_mem_ack |=> !o_mem_req [*3])
        else $error("fetch before word taken");
    tdo_fall_a: assert property ($changed(o_tdo) |-> !$past(i_tck) && !$past(i_tck, 2))
        else $error("data out changed with clock high");
    cov_prog: cover property ($rose(o_prog_mode));
    cov_req: cover property ($rose(o_mem_req));
    cov_ack: cover property (i_mem_ack);
    cov_ext: cover property ($rose(o_clk_ext_sel));
endmodule // jsfp_core_props

bind jsfp_core jsfp_core_props #(.DET_W(DET_W), .DET_CYCLES(DET_CYCLES)) u_props (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_test_select_input(i_test_select_input), .i_prog_enable_sel_a(i_prog_enable_sel_a),
    .i_prog_enable_sel_b(i_prog_enable_sel_b), .i_prog_enable_sel_c(i_prog_enable_sel_c),
    .i_main_clock_input(i_main_clock_input), .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi),
    .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_test_mode(o_test_mode),
    .o_prog_mode(o_prog_mode), .o_ready(o_ready), .o_clk_ext_sel(o_clk_ext_sel),
    .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .i_mem_rdata(i_mem_rdata),
    .i_mem_ack(i_mem_ack));

/* File: bench/jsfp_mem_model.sv */
module jsfp_mem_model (
    input  wire        i_clk_sys,
    input  wire        i_rst_n,
    input  wire        i_req,
    input  wire [31:0] i_addr,
    output reg         o_ack,
    output wire [31:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    integer     seed = 81778;
    reg  [31:0] rnd;
    reg  [1:0]  wait_cnt;
    // Word per address, inverse pattern outside the answer
    assign o_rdata = o_ack ? {i_addr[15:0], ~i_addr[15:0]} : ~{i_addr[15:0], ~i_addr[15:0]};
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ack <= 1'b0;
            wait_cnt <= 2'h0;
            rnd <= 32'h0;
        end else if (i_req && !o_ack) begin
            if (wait_cnt == 2'h0) begin
                o_ack <= 1'b1;
                wait_cnt <= rnd[1:0];
                rnd <= $random(seed);
            end else begin
                wait_cnt <= wait_cnt - 2'h1;
            end
        end else begin
            o_ack <= 1'b0;
        end
    end
endmodule // jsfp_mem_model

/* File: bench/jsfp_core_tb.sv */
module jsfp_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg         i_clk_sys, i_rst_n, i_ce, i_tck, i_tms, i_tdi, i_main_clock_input;
    reg         i_test_select_input, i_prog_enable_sel_a, i_prog_enable_sel_b;
    reg         i_prog_enable_sel_c, tdo_s, oe_s;
    wire        o_tdo, o_tdo_oe, o_test_mode, o_prog_mode, o_ready, o_clk_ext_sel;
    wire        o_mem_req, i_mem_ack;
    wire [31:0] o_mem_addr, i_mem_rdata;
    integer     err_count, checks, seed, i, j, k, p, cnt;
    reg  [37:0] dout;
    reg  [31:0] base;
    jsfp_core #(.DET_W(16), .DET_CYCLES(64)) u_jsfp_core (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce),
        .i_test_select_input(i_test_select_input), .i_prog_enable_sel_a(i_prog_enable_sel_a),
        .i_prog_enable_sel_b(i_prog_enable_sel_b), .i_prog_enable_sel_c(i_prog_enable_sel_c),
        .i_main_clock_input(i_main_clock_input), .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi),
        .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_test_mode(o_test_mode),
        .o_prog_mode(o_prog_mode), .o_ready(o_ready), .o_clk_ext_sel(o_clk_ext_sel),
        .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .i_mem_rdata(i_mem_rdata),
        .i_mem_ack(i_mem_ack));
    jsfp_mem_model u_jsfp_mem_model (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_req(o_mem_req), .i_addr(o_mem_addr), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end
    // ****************************************
    // Tasks
    // ****************************************
    function [31:0] exp_word(input [31:0] a);
        exp_word = {a[15:0], ~a[15:0]};
    endfunction
    task chk(input [31:0] got, input [31:0] exp, input string what);
        checks = checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("BAD %0t %0s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task tck_cyc(input t, input d);
        @(posedge i_clk_sys);
        i_tck <= 1'b0;
        i_tms <= t;
        i_tdi <= d;
        repeat (16) @(posedge i_clk_sys);
        tdo_s = o_tdo;
        oe_s = o_tdo_oe;
        i_tck <= 1'b1;
        repeat (15) @(posedge i_clk_sys);
    endtask
    task scan(input ir, input integer n, input [37:0] din);
        if (ir) tck_cyc(1'b1, 1'b0);
        tck_cyc(1'b0, 1'b0);
        tck_cyc(1'b0, 1'b0);
        for (k = 0; k < n; k = k + 1) begin
            tck_cyc(k == n - 1, din[k]);
            dout[k] = tdo_s;
        end
        chk(oe_s, 1'b1, "data out enable in shift");
        tck_cyc(1'b1, 1'b0);
        tck_cyc(1'b1, 1'b0);
        chk(oe_s, 1'b0, "data out enable idle");
    endtask
    task reg_rd(input [4:0] a);
        scan(1'b0, 38, {1'b0, a, 32'h0});
        scan(1'b0, 38, {1'b0, 5'h04, 32'h0});
    endtask
    task wr(input [31:0] d);
        p = 0;
        do begin reg_rd(5'h04); p = p + 1; end while (dout[0] && p < 20);
        chk(dout[0], 1'b0, "write pending stuck");
        scan(1'b0, 38, {1'b1, 5'h05, d});
    endtask
    task rd_data(input [31:0] exp);
        p = 0;
        do begin reg_rd(5'h04); p = p + 1; end while (!dout[1] && p < 20);
        chk(dout[1], 1'b1, "no word available");
        reg_rd(5'h05);
        chk(dout[31:0], exp, "read word");
    endtask
    task complete_run;
        $display("Counts: checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        seed = 81778;
        err_count = 0;
        checks = 0;
        {i_rst_n, i_ce, i_tck, i_tms, i_tdi, i_main_clock_input} = 6'b011110;
        {i_test_select_input, i_prog_enable_sel_a, i_prog_enable_sel_b} = 3'b111;
        i_prog_enable_sel_c = 1'b0;
        repeat (4) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (20) begin
            repeat (2) @(posedge i_clk_sys);
            i_main_clock_input <= ~i_main_clock_input;
        end
        repeat (60) @(posedge i_clk_sys);
        chk(o_ready, 1'b1, "ready");
        chk(o_clk_ext_sel, 1'b1, "ext clock");
        chk(o_test_mode, 1'b1, "test mode");
        repeat (5) tck_cyc(1'b1, 1'b0);
        tck_cyc(1'b0, 1'b0);
        tck_cyc(1'b1, 1'b0);
        scan(1'b1, 4, 38'h2);
        chk(dout[3:0], 4'h1, "ir capture");
        scan(1'b0, 4, 38'h2);
        scan(1'b1, 4, 38'hc);
        chk(o_prog_mode, 1'b1, "prog mode");
        reg_rd(5'h04);
        chk(dout[1:0], 2'b00, "idle flags");
        scan(1'b0, 38, {1'b1, 5'h04, 32'hffffffff});
        reg_rd(5'h04);
        chk(dout[1:0], 2'b00, "flags written");
        $display("entry and flags test done");
        wr(($random(seed) & 32'hfff0fff0) | 32'h00010000);
        reg_rd(5'h04);
        chk(dout[1:0], 2'b00, "foreign command");
        $display("foreign command test done");
        for (i = 0; i < 2; i = i + 1) begin
            cnt = (i == 0) ? 3 : 1;
            base = ($random(seed) & 32'h0000fffc) | ((i == 0) ? 32'h0 : 32'h3);
            wr({cnt[15:0], 16'h000f});
            wr(base);
            for (j = 0; j < cnt; j = j + 1) begin
                rd_data(exp_word((base & 32'hfffffffc) + 32'h4 * j));
            end
            $display("read command test %0d done", i);
        end
        i_rst_n <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (80) @(posedge i_clk_sys);
        chk(o_clk_ext_sel, 1'b0, "no ext clock");
        chk(o_prog_mode, 1'b0, "prog mode after reset");
        $display("clock detect test done");
        i_prog_enable_sel_c <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        chk(o_test_mode, 1'b0, "test mode without pins");
        $display("pin select test done");
        complete_run;
    end
    initial begin
        #450000;
        err_count = err_count + 1;
        $display("BAD %0t watchdog", $time);
        complete_run;
    end
endmodule // jsfp_core_tb
